// ==== adcs_sequencer.sv ====
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "adcs_cfg.svh"

// Function
// - Power-on reset leaves both result registers untouched, contents undefined.
// - Two conversion-bit periods pass after completion before acquisition resumes.
// - A conversion lasts twelve conversion-bit periods from start to result.
// - Clock code picks 2,4,8,16,32,64 oscillator periods, or the RC clock.
// - Allowed device frequency scales with divider; RC source has no limit.
// - A pin driven as output converts its own digital level.
// - Channel and pin direction never block or alter sequencing.
// - Port readback shows zero on every analog-configured pin.
// - A digital-input pin is still converted when selected.
// - Clearing go mid-conversion aborts with no partial result written.
// - After abort, results keep the last completed or written value.
// - After abort, wait two bit periods, then acquisition restarts.
// - Ten-bit result lands left or right justified in the pair.
// - Six unused result bits load zero on every completed conversion.
// - Result registers are plain read/write bytes when not overwritten.
// - Starting a conversion releases the hold from the input.
// - Completion loads results, clears go and sets the done flag.
// - Format one right-justifies, zero left-justifies.
// - Reset turns the converter off and aborts any conversion.
// - Power bit switches converter; conversions start only while powered.
module adcs_sequencer
    import adcs_pkg::*;
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire adcs_apb_req_type apb_req,
    output var  adcs_apb_rsp_type apb_rsp,
    input  wire logic             rc_clk,
    input  wire logic [9:0]       sar_code,
    input  wire logic [7:0]       pin_level,
    output logic                  sample_track,
    output logic                  converter_power_on,
    output logic [2:0]            channel_select,
    output logic                  conversion_done_irq_flag
);

    // ==================================================
    // State
    typedef struct packed {
        adcs_state_type state;
        logic           go;
        logic           on;
        logic           fmt;
        logic           irq_flag;
        logic           irq_en;
        logic [2:0]     clk_sel;
        logic [2:0]     chan;
        logic [3:0]     pcfg;
        logic [5:0]     div_cnt;
        logic [3:0]     tad_cnt;
        logic           rc_s1;
        logic           rc_s2;
        logic           rc_prev;
        logic [9:0]     code_s1;
        logic [9:0]     code_s2;
        logic [7:0]     pin_s1;
        logic [7:0]     pin_s2;
        logic [31:0]    prdata;
        logic           pslverr;
    } adcs_regs_type;

    adcs_regs_type q_reg;
    adcs_regs_type q_next;
    logic [7:0]    res_hi_reg;
    logic [7:0]    res_lo_reg;
    logic          setup;
    logic          access;
    logic          wr;
    logic          ctl0_wr;
    logic          tad_tick;
    logic          done;
    logic          abort;
    logic [6:0]    div_len;
    logic [7:0]    amask;
    logic [15:0]   justified;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Analog pins per port configuration; reference pins count as analog
    function automatic logic [7:0] analog_mask(input logic [3:0] cfg);
        logic [7:0] m;
        m = 8'h00;
        case (cfg)
            4'h0, 4'h1, 4'h8:        m = 8'hFF;
            4'h2, 4'h3, 4'hC:        m = 8'h1F;
            4'h4, 4'h5:              m = 8'h0B;
            4'h9, 4'hA, 4'hB:        m = 8'h3F;
            4'hD:                    m = 8'h0F;
            4'hE:                    m = 8'h01;
            4'hF:                    m = 8'h0D;
            default:                 m = 8'h00;
        endcase
        return m;
    endfunction

    // ==================================================
    // Bus decode and bit-period divider
    assign setup  = apb_req.psel && !apb_req.penable;
    assign access = apb_req.psel && apb_req.penable;
    assign wr     = access && apb_req.pwrite;
    assign amask  = analog_mask(q_reg.pcfg);

    // Code steps 2,4,8,.. as 2 to the power 1+2*low+high
    assign div_len = `ADCS_DIV_UNIT << (3'(1) + {q_reg.clk_sel[1:0], 1'b0}
                     + {2'b00, q_reg.clk_sel[2]});

    // RC edges only reach logic after the two-stage synchroniser
    assign tad_tick = (q_reg.clk_sel[1:0] == `ADCS_RC_CODE)
                    ? (q_reg.rc_s2 && !q_reg.rc_prev)
                    : (q_reg.div_cnt == 6'(div_len - `ADCS_DIV_UNIT));

    assign ctl0_wr = wr && (apb_req.paddr == `ADCS_OFF_CTL0);
    // A write clearing go or power in the last cycle wins over completion
    assign done  = (q_reg.state == ADCS_CONV) && q_reg.go && q_reg.on && tad_tick
                && (q_reg.tad_cnt == `ADCS_CONV_TADS - 4'h1)
                && !(ctl0_wr && !(apb_req.pwdata[`ADCS_C0_GO]
                                  && apb_req.pwdata[`ADCS_C0_ON]));
    assign abort = (q_reg.state == ADCS_CONV) && q_reg.on && ctl0_wr
                && apb_req.pwdata[`ADCS_C0_ON]
                && !apb_req.pwdata[`ADCS_C0_GO];

    // Right keeps upper six zero, left keeps lower six zero
    assign justified = q_reg.fmt ? {6'h00, q_reg.code_s2}
                                 : {q_reg.code_s2, 6'h00};

    // ==================================================
    // Next state
    always_comb begin
        q_next = q_reg;
        q_next.rc_s1   = rc_clk;
        q_next.rc_s2   = q_reg.rc_s1;
        q_next.rc_prev = q_reg.rc_s2;
        q_next.code_s1 = sar_code;
        q_next.code_s2 = q_reg.code_s1;
        q_next.pin_s1  = pin_level;
        q_next.pin_s2  = q_reg.pin_s1;

        if (setup) begin
            q_next.pslverr = 1'b0;
            case (apb_req.paddr)
                `ADCS_OFF_CTL0: q_next.prdata = {24'h00_0000, q_reg.clk_sel[1:0],
                                                 q_reg.chan, q_reg.go, 1'b0, q_reg.on};
                `ADCS_OFF_CTL1: q_next.prdata = {24'h00_0000, q_reg.fmt, q_reg.clk_sel[2],
                                                 2'b00, q_reg.pcfg};
                `ADCS_OFF_RESH: q_next.prdata = {24'h00_0000, res_hi_reg};
                `ADCS_OFF_RESL: q_next.prdata = {24'h00_0000, res_lo_reg};
                `ADCS_OFF_STAT: q_next.prdata = {30'h0000_0000, q_reg.irq_en,
                                                 q_reg.irq_flag};
                `ADCS_OFF_PORT: q_next.prdata = {24'h00_0000,
                                                 q_reg.pin_s2 & ~amask};
                default: begin
                    q_next.prdata  = 32'h0000_0000;
                    q_next.pslverr = 1'b1;
                end
            endcase
        end

        if (wr) begin
            case (apb_req.paddr)
                `ADCS_OFF_CTL0: begin
                    q_next.on = apb_req.pwdata[`ADCS_C0_ON];
                    q_next.chan = apb_req.pwdata[`ADCS_C0_CH_LSB +: 3];
                    q_next.clk_sel[1:0] = apb_req.pwdata[`ADCS_C0_CS_LSB +: 2];
                    // Go needs the converter already powered before this write
                    q_next.go = apb_req.pwdata[`ADCS_C0_GO] && q_reg.on
                             && apb_req.pwdata[`ADCS_C0_ON];
                end
                `ADCS_OFF_CTL1: begin
                    q_next.fmt        = apb_req.pwdata[`ADCS_C1_FMT];
                    q_next.clk_sel[2] = apb_req.pwdata[`ADCS_C1_CS2];
                    q_next.pcfg       = apb_req.pwdata[`ADCS_C1_PCFG_LSB +: 4];
                end
                `ADCS_OFF_STAT: begin
                    q_next.irq_flag = apb_req.pwdata[`ADCS_ST_FLAG];
                    q_next.irq_en   = apb_req.pwdata[`ADCS_ST_EN];
                end
                default: begin
                end
            endcase
        end

        if (q_reg.state == ADCS_IDLE) begin
            q_next.div_cnt = 6'h00;
        end else if (tad_tick) begin
            q_next.div_cnt = 6'h00;
        end else begin
            q_next.div_cnt = q_reg.div_cnt + 6'h01;
        end

        case (q_reg.state)
            ADCS_IDLE: begin
                // Channel and direction settings play no part here
                if (q_reg.go && q_reg.on) begin
                    q_next.state   = ADCS_CONV;
                    q_next.tad_cnt = 4'h0;
                end
            end
            ADCS_CONV: begin
                if (!q_next.on) begin
                    q_next.state = ADCS_IDLE;
                    q_next.go    = 1'b0;
                end else if (abort) begin
                    q_next.state   = ADCS_RECOVER;
                    q_next.tad_cnt = 4'h0;
                    // Restart divider so recovery is two whole periods; RC phase runs free
                    q_next.div_cnt = 6'h00;
                end else if (done) begin
                    q_next.state    = ADCS_RECOVER;
                    q_next.tad_cnt  = 4'h0;
                    q_next.go       = 1'b0;
                    q_next.irq_flag = 1'b1;
                end else if (tad_tick) begin
                    q_next.tad_cnt = q_reg.tad_cnt + 4'h1;
                end
            end
            ADCS_RECOVER: begin
                if (!q_next.on) begin
                    q_next.state = ADCS_IDLE;
                    q_next.go    = 1'b0;
                end else if (tad_tick) begin
                    if (q_reg.tad_cnt == `ADCS_REC_TADS - 4'h1) begin
                        q_next.state = ADCS_IDLE;
                    end else begin
                        q_next.tad_cnt = q_reg.tad_cnt + 4'h1;
                    end
                end
            end
            default: begin
                q_next.state = ADCS_IDLE;
            end
        endcase
    end

    // Reset forces everything off and drops any running conversion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    // ==================================================
    // Result pair; no reset so power-on leaves it as found
    // Completion wins over a software write in the same cycle
    always_ff @(posedge pclk) begin
        if (done) begin
            res_hi_reg <= justified[15:8];
            res_lo_reg <= justified[7:0];
        end else if (wr && apb_req.paddr == `ADCS_OFF_RESH) begin
            res_hi_reg <= apb_req.pwdata[7:0];
        end else if (wr && apb_req.paddr == `ADCS_OFF_RESL) begin
            res_lo_reg <= apb_req.pwdata[7:0];
        end
    end

    // ==================================================
    // Outputs
    // Code is taken as the front end delivers it, pin mode regardless
    assign sample_track = q_reg.on && (q_reg.state == ADCS_IDLE) && !q_reg.go;
    assign converter_power_on       = q_reg.on;
    assign channel_select           = q_reg.chan;
    assign conversion_done_irq_flag = q_reg.irq_flag;
    assign apb_rsp.prdata  = q_reg.prdata;
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = access && q_reg.pslverr;

    // ==================================================
    // Checks
    a_conv_length: assert property (done |-> q_reg.tad_cnt == 4'hB)
        else $error("conversion did not last twelve bit periods");
    a_done_effects: assert property (
        done |=> !q_reg.go && q_reg.irq_flag && q_reg.state == ADCS_RECOVER)
        else $error("completion did not clear go and set flag");
    // Results start unknown; this check means something once one was written
    a_abort_keeps: assert property (
        abort |=> $stable(res_hi_reg) && $stable(res_lo_reg))
        else $error("aborted conversion changed the result");
    a_abort_flag: assert property (
        abort && !q_reg.irq_flag |=> !q_reg.irq_flag)
        else $error("aborted conversion set the done flag");
    a_abort_recover: assert property (
        abort |=> q_reg.state == ADCS_RECOVER && !sample_track)
        else $error("abort did not enter recovery");
    a_recover_end: assert property (
        q_reg.state == ADCS_RECOVER && tad_tick
        && q_reg.tad_cnt == `ADCS_REC_TADS - 4'h1 |=> q_reg.state == ADCS_IDLE)
        else $error("recovery did not end after two bit periods");
    a_recover_quiet: assert property (q_reg.state == ADCS_RECOVER |-> !sample_track)
        else $error("sampling resumed during recovery");
    a_track_held: assert property (q_reg.state == ADCS_CONV |-> !sample_track)
        else $error("input tracked during conversion");
    a_start_powered: assert property (
        $rose(q_reg.state == ADCS_CONV) |-> $past(q_reg.on) && !sample_track)
        else $error("conversion started unpowered or still sampling");
    a_go_powered: assert property (
        wr && apb_req.paddr == `ADCS_OFF_CTL0 && !q_reg.on |=> !q_reg.go)
        else $error("go accepted while converter unpowered");
    a_off_clears: assert property (
        wr && apb_req.paddr == `ADCS_OFF_CTL0 && !apb_req.pwdata[`ADCS_C0_ON]
        |=> !q_reg.go ##1 q_reg.state == ADCS_IDLE)
        else $error("power off left a conversion running");
    a_right_just: assert property (done && q_reg.fmt |=> res_hi_reg[7:2] == 6'h00)
        else $error("right justified high bits not zero");
    a_left_just: assert property (done && !q_reg.fmt |=> res_lo_reg[5:0] == 6'h00)
        else $error("left justified low bits not zero");
    a_port_masked: assert property (
        setup && !apb_req.pwrite && apb_req.paddr == `ADCS_OFF_PORT
        |=> (q_reg.prdata[7:0] & amask) == 8'h00)
        else $error("analog pin read back nonzero");
    a_read_upper: assert property (
        setup && !apb_req.pwrite |=> q_reg.prdata[31:8] == 24'h00_0000)
        else $error("register read set bits above the byte");
    a_fast_div: assert property (
        q_reg.state == ADCS_CONV && q_reg.clk_sel == 3'b000 && $stable(q_reg.clk_sel)
        && tad_tick && !wr ##1 !wr |-> !tad_tick ##1 tad_tick)
        else $error("bit period not two clocks");
    a_off_stops: assert property (!q_reg.on |=> q_reg.state != ADCS_CONV)
        else $error("conversion ran while off");

    // ==================================================
    // Cover points
    c_done:  cover property (done);
    c_abort: cover property (abort);
    c_rc:    cover property (done && q_reg.clk_sel[1:0] == `ADCS_RC_CODE);
    c_swres: cover property (wr && apb_req.paddr == `ADCS_OFF_RESH && !q_reg.on);
    c_right: cover property (done && q_reg.fmt);

endmodule

`default_nettype wire

// ==== adcs_cfg.svh ====
`ifndef ADCS_CFG_SVH
`define ADCS_CFG_SVH

// ==================================================
// Register byte offsets
`define ADCS_OFF_CTL0      8'h00
`define ADCS_OFF_CTL1      8'h04
`define ADCS_OFF_RESH      8'h08
`define ADCS_OFF_RESL      8'h0C
`define ADCS_OFF_STAT      8'h10
`define ADCS_OFF_PORT      8'h14

// ==================================================
// Field positions
`define ADCS_C0_ON         0
`define ADCS_C0_GO         2
`define ADCS_C0_CH_LSB     3
`define ADCS_C0_CS_LSB     6
`define ADCS_C1_PCFG_LSB   0
`define ADCS_C1_CS2        6
`define ADCS_C1_FMT        7
`define ADCS_ST_FLAG       0
`define ADCS_ST_EN         1

// ==================================================
// Timing in conversion-bit periods and clock codes
`define ADCS_CONV_TADS     4'h0C
`define ADCS_REC_TADS      4'h2
`define ADCS_RC_CODE       2'b11
`define ADCS_DIV_UNIT      7'h01

`endif

// ==== adcs_pkg.sv ====
package adcs_pkg;

    typedef enum logic [1:0] {
        ADCS_IDLE    = 2'b00,
        ADCS_CONV    = 2'b01,
        ADCS_RECOVER = 2'b10
    } adcs_state_type;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } adcs_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } adcs_apb_rsp_type;

endpackage

// ==== adcs_front_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==================================================
// Sample-and-hold front end with per-channel levels
module adcs_front_model (
    input  wire logic       pclk,
    input  wire logic       sample_track,
    input  wire logic [2:0] channel_select,
    output logic            rc_clk,
    output logic [9:0]      sar_code,
    output logic [7:0]      pin_level
);
    logic [9:0] held_code;

    // RC oscillator free running, no phase tie to pclk
    initial begin
        rc_clk = 1'b0;
        forever #55 rc_clk = ~rc_clk;
    end

    // Hold stage follows the channel only while tracking
    always_ff @(posedge pclk) begin
        if (sample_track) begin
            held_code <= {channel_select, 7'h2B};
        end
    end

    // Inverted level while tracking, so an early sample shows up
    assign sar_code  = sample_track ? ~held_code : held_code;
    assign pin_level = 8'hA7;
endmodule

`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "adcs_cfg.svh"

module tb
    import adcs_pkg::*;
;
    logic             pclk;
    logic             presetn;
    adcs_apb_req_type apb_req;
    adcs_apb_rsp_type apb_rsp;
    logic             rc_clk;
    logic [9:0]       sar_code;
    logic [7:0]       pin_level;
    logic             sample_track;
    logic             converter_power_on;
    logic [2:0]       channel_select;
    logic             conversion_done_irq_flag;
    int               failures;
    int               n_tests;
    logic [31:0]      rd;
    logic             err;
    int               c;
    logic [2:0]       csel [7] = '{3'b000, 3'b100, 3'b001, 3'b101, 3'b010, 3'b110, 3'b011};
    int               conversion_bit_period  [7] = '{2, 4, 8, 16, 32, 64, 5};

    adcs_sequencer adcs_sequencer_inst (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .rc_clk(rc_clk), .sar_code(sar_code), .pin_level(pin_level),
        .sample_track(sample_track), .converter_power_on(converter_power_on),
        .channel_select(channel_select), .conversion_done_irq_flag(conversion_done_irq_flag));
    adcs_front_model adcs_front_model_inst (.pclk(pclk), .sample_track(sample_track),
        .channel_select(channel_select), .rc_clk(rc_clk), .sar_code(sar_code),
        .pin_level(pin_level));

    // ==================================================
    // Helpers
    function automatic logic [31:0] w8(input logic [7:0] b);
        return {24'h00_0000, b};
    endfunction

    function automatic logic [31:0] inr(input int v, input int lo, input int hi);
        return (v >= lo && v <= hi) ? 32'h0000_0001 : 32'h0000_0000;
    endfunction

    function automatic logic [7:0] amask(input logic [3:0] p);
        case (p)
            4'h0, 4'h1, 4'h8: return 8'hFF;
            4'h2, 4'h3, 4'hC: return 8'h1F;
            4'h4, 4'h5:       return 8'h0B;
            4'h6, 4'h7:       return 8'h00;
            4'h9, 4'hA, 4'hB: return 8'h3F;
            4'hD:             return 8'h0F;
            4'hE:             return 8'h01;
            default:          return 8'h0D;
        endcase
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // ==================================================
    // APB master, zero or more wait states
    task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        int w;
        @(posedge pclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        w = 0;
        do begin
            @(posedge pclk);
            w++;
        end while (apb_rsp.pready !== 1'b1 && w < 50);
        if (apb_rsp.pready !== 1'b1) failures++;
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
        apb_xfer(1'b1, addr, wd);
    endtask

    task automatic rdc(input logic [7:0] addr, input logic [31:0] exp);
        apb_xfer(1'b0, addr, 32'h0000_0000);
        chk(rd, exp);
    endtask

    task automatic wait_track();
        c = 0;
        while (sample_track !== 1'b1 && c < 500) begin
            @(posedge pclk);
            c++;
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ==================================================
    // Clock, reset, watchdog
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // Whole sequence needs about 2300 cycles; the 40000-cycle limit, some seventeen times that, is a hang
    initial begin
        #(40000 * 25);
        failures++;
        conclude();
    end

    // ==================================================
    // Tests
    initial begin
        logic [9:0] code;
        logic [2:0] cs;
        logic [2:0] ch;
        logic       fmt;
        int         t;
        failures = 0;
        n_tests = 0;
        presetn = 1'b0;
        apb_req = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;

        for (int p = 0; p < 16; p++) begin
            wr(`ADCS_OFF_CTL1, w8(p[7:0]));
            rdc(`ADCS_OFF_PORT, w8(8'hA7 & ~amask(p[3:0])));
        end
        apb_xfer(1'b0, 8'h18, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
        $display("test port_readback done");

        for (int i = 0; i < 7; i++) begin
            ch = i[2:0];
            fmt = i[0];
            cs = csel[i];
            t = conversion_bit_period[i];
            code = {ch, 7'h2B};
            wr(`ADCS_OFF_CTL1, w8({fmt, cs[2], 6'h00}));
            wr(`ADCS_OFF_CTL0, w8({cs[1:0], ch, 3'b001}));
            wr(`ADCS_OFF_STAT, 32'h0000_0002);
            repeat (8) @(posedge pclk);
            wr(`ADCS_OFF_CTL0, w8({cs[1:0], ch, 3'b101}));
            c = 0;
            while (conversion_done_irq_flag !== 1'b1 && c < 2000) begin
                @(posedge pclk);
                c++;
            end
            chk(inr(c, 12 * t - ((cs == 3'b011) ? 12 : 0), 13 * t + 4), 1);
            wait_track();
            chk(inr(c, 2 * t - 2, 3 * t + 3), 32'h0000_0001);
            rdc(`ADCS_OFF_CTL0, w8({cs[1:0], ch, 3'b001}));
            rdc(`ADCS_OFF_STAT, 32'h0000_0003);
            rdc(`ADCS_OFF_RESH, fmt ? w8({6'h00, code[9:8]}) : w8(code[9:2]));
            rdc(`ADCS_OFF_RESL, fmt ? w8(code[7:0]) : w8({code[1:0], 6'h00}));
        end
        $display("test conversions done");

        wr(`ADCS_OFF_CTL0, 32'h0000_0000);
        wr(`ADCS_OFF_RESH, w8(8'h5A));
        wr(`ADCS_OFF_RESL, w8(8'hC3));
        rdc(`ADCS_OFF_RESH, w8(8'h5A));
        rdc(`ADCS_OFF_RESL, w8(8'hC3));
        wr(`ADCS_OFF_CTL1, w8(8'h80));
        wr(`ADCS_OFF_CTL0, w8(8'h09));
        wr(`ADCS_OFF_STAT, 32'h0000_0000);
        wr(`ADCS_OFF_CTL0, w8(8'h0D));
        repeat (6) @(posedge pclk);
        wr(`ADCS_OFF_CTL0, w8(8'h09));
        wait_track();
        chk(inr(c, 2 * 2, 2 * 2 + 1), 32'h0000_0001);
        chk({31'h0, conversion_done_irq_flag}, 32'h0000_0000);
        rdc(`ADCS_OFF_RESH, w8(8'h5A));
        rdc(`ADCS_OFF_RESL, w8(8'hC3));
        $display("test abort done");

        wr(`ADCS_OFF_CTL0, w8(8'h0D));
        repeat (5) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({31'h0, converter_power_on}, 32'h0000_0000);
        rdc(`ADCS_OFF_CTL0, 32'h0000_0000);
        rdc(`ADCS_OFF_RESH, w8(8'h5A));
        wr(`ADCS_OFF_CTL0, w8(8'h05));
        rdc(`ADCS_OFF_CTL0, w8(8'h01));
        wr(`ADCS_OFF_CTL0, 32'h0000_0000);
        wr(`ADCS_OFF_CTL0, w8(8'h04));
        rdc(`ADCS_OFF_CTL0, 32'h0000_0000);
        $display("test reset_and_power done");
        conclude();
    end
endmodule

`default_nettype wire
